// File: rtl/sep_defines.svh
`ifndef SEP_DEFINES_SVH
`define SEP_DEFINES_SVH

`define SEP_CLK_PERIOD_NS 25
`define SEP_LOAD_TIME_MS  10
`define SEP_WRITE_TIME_MS 10
`define SEP_LOAD_CYCLES   ((`SEP_LOAD_TIME_MS * 1000000) / `SEP_CLK_PERIOD_NS)
`define SEP_WRITE_CYCLES  ((`SEP_WRITE_TIME_MS * 1000000) / `SEP_CLK_PERIOD_NS)
`define SEP_SCL_PERIOD_NS 2500
`define SEP_QUARTER_CYC   (`SEP_SCL_PERIOD_NS / `SEP_CLK_PERIOD_NS / 4)
// Arbitrary value
`define SEP_DEV_TYPE      4'h5
`define SEP_SEL_ADDR      16'hff09
`define SEP_SEL_RESET     3'h0
`define SEP_MEM_BYTES     512
`define SEP_PAGE_BYTES    8
`define SEP_FIFO_WIDTH    9
`define SEP_FIFO_DEPTH    16

`endif

// File: rtl/sep_pkg.sv
package sep_pkg;
	typedef enum logic [2:0] {
		SEP_OP_START,
		SEP_OP_STOP,
		SEP_OP_WRITE,
		SEP_OP_READ_ACK,
		SEP_OP_READ_NACK
	} sep_op_type;

	typedef struct packed {
		sep_op_type  op;
		logic [7:0]  data;
	} sep_cmd_type;

	typedef enum {
		SEP_DS_IDLE,
		SEP_DS_RX,
		SEP_DS_ACK,
		SEP_DS_TX,
		SEP_DS_MACK
	} sep_dev_state_type;

	typedef enum {
		SEP_RL_SLAVE,
		SEP_RL_ADDR_HI,
		SEP_RL_ADDR_LO,
		SEP_RL_DATA
	} sep_role_type;

	typedef enum {
		SEP_HS_IDLE,
		SEP_HS_START,
		SEP_HS_STOP,
		SEP_HS_BIT
	} sep_host_state_type;
endpackage

// File: rtl/sep_if.sv
`timescale 1ns/1ps
interface sep_if;
	logic host_scl_o;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain data line with pull-up
	assign scl = host_scl_o;
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport host (
		output host_scl_o,
		output host_sda_o,
		output host_sda_oe,
		input  sda
	);
endinterface

// File: rtl/sep_device.sv
`timescale 1ns/1ps
`include "sep_defines.svh"
module sep_device
	import sep_pkg::*;
#(
	parameter int LOAD_CYCLES  = `SEP_LOAD_CYCLES,
	parameter int WRITE_CYCLES = `SEP_WRITE_CYCLES
) (
	sep_if.dev        bus,
	input  wire logic clk_i,
	input  wire logic rst_i,
	output logic      ready_o,
	output logic      busy_o
);
	localparam logic [15:0] SEL_ADDR = `SEP_SEL_ADDR;

	logic [7:0]        mem [`SEP_MEM_BYTES];
	logic [7:0]        page_buf [`SEP_PAGE_BYTES];
	logic [1:0]        scl_sync;
	logic [1:0]        sda_sync;
	logic              scl_d;
	logic              sda_d;
	sep_dev_state_type state;
	sep_role_type      role;
	logic              rw;
	logic [3:0]        bit_cnt;
	logic [7:0]        shift;
	logic [7:0]        addr_hi;
	logic [8:0]        counter;
	logic              sel_hit;
	logic [7:0]        page_valid;
	logic [3:0]        page_count;
	logic              loading;
	logic [19:0]       load_cnt;
	logic              busy;
	logic [19:0]       write_cnt;
	logic [2:0]        select_ref;
	logic [2:0]        select_store;
	logic              sda_drive;
	logic              sda_out;

	wire        scl_s      = scl_sync[1];
	wire        sda_s      = sda_sync[1];
	wire        scl_rise   = scl_s & ~scl_d;
	wire        scl_fall   = ~scl_s & scl_d;
	wire        start_det  = scl_s & scl_d & sda_d & ~sda_s;
	wire        stop_det   = scl_s & scl_d & ~sda_d & sda_s;
	wire        type_ok    = shift[7:4] == `SEP_DEV_TYPE;
	wire        addr_match = type_ok && shift[3:1] == select_ref;
	wire [8:0]  next_page  = {counter[8:3], counter[2:0] + 3'h1};
	wire [8:0]  next_read  = counter + 9'h001;
	wire [7:0]  read_byte  = mem[counter];
	wire        load_done  = loading && load_cnt == 20'(LOAD_CYCLES - 1);
	wire        write_done = busy && write_cnt == 20'(WRITE_CYCLES - 1);
	wire        commit_go  = stop_det && !busy && role == SEP_RL_DATA && page_count != 4'h0;
	wire        byte_end   = scl_fall && bit_cnt == 4'h8;
	wire [7:0]  sel_mask   = 8'h01 << SEL_ADDR[2:0];

	assign bus.dev_sda_o  = sda_out;
	assign bus.dev_sda_oe = sda_drive;

	// Pins pass two flops before any edge logic
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			scl_d    <= 1'b1;
			sda_d    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], bus.scl};
			sda_sync <= {sda_sync[0], bus.sda};
			scl_d    <= scl_sync[1];
			sda_d    <= sda_sync[1];
		end
	end

	// Select code copy after reset, then the timed write cycle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			loading    <= 1'b1;
			load_cnt   <= 20'h00000;
			select_ref <= `SEP_SEL_RESET;
			busy       <= 1'b0;
			write_cnt  <= 20'h00000;
			ready_o    <= 1'b0;
			busy_o     <= 1'b0;
		end else begin
			if (load_done) begin
				loading    <= 1'b0;
				select_ref <= select_store;
			end else if (loading) begin
				load_cnt <= load_cnt + 20'h00001;
			end
			if (commit_go) begin
				busy      <= 1'b1;
				write_cnt <= 20'h00000;
			end else if (write_done) begin
				busy <= 1'b0;
			end else if (busy) begin
				write_cnt <= write_cnt + 20'h00001;
			end
			ready_o <= ~loading;
			busy_o  <= busy;
		end
	end

	// Stored code lives outside the array; reset sets it back to SEP_SEL_RESET before the copy, so it never takes effect
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			select_store <= `SEP_SEL_RESET;
		end else if (write_done && sel_hit && page_valid == sel_mask) begin
			select_store <= page_buf[SEL_ADDR[2:0]][2:0];
		end
	end

	// Array is written once per cycle end unless sel_hit, all valid page slots together
	always_ff @(posedge clk_i) begin
		if (write_done && !sel_hit) begin
			for (int i = 0; i < `SEP_PAGE_BYTES; i++) begin
				if (page_valid[i]) begin
					mem[{counter[8:3], 3'(i)}] <= page_buf[i];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (state == SEP_DS_RX && byte_end && role == SEP_RL_DATA && !busy) begin
			page_buf[counter[2:0]] <= shift;
		end
	end

	// Protocol engine
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state      <= SEP_DS_IDLE;
			role       <= SEP_RL_SLAVE;
			rw         <= 1'b0;
			bit_cnt    <= 4'h0;
			shift      <= 8'h00;
			addr_hi    <= 8'h00;
			counter    <= 9'h000;
			sel_hit    <= 1'b0;
			page_valid <= 8'h00;
			page_count <= 4'h0;
			sda_drive  <= 1'b0;
			sda_out    <= 1'b0;
		end else if (start_det && !loading) begin
			state     <= SEP_DS_RX;
			role      <= SEP_RL_SLAVE;
			bit_cnt   <= 4'h0;
			sda_drive <= 1'b0;
		end else if (stop_det) begin
			state      <= SEP_DS_IDLE;
			sda_drive  <= 1'b0;
			page_count <= 4'h0;
		end else begin
			unique case (state)
				SEP_DS_IDLE: begin
				end
				SEP_DS_RX: begin
					if (scl_rise && bit_cnt != 4'h8) begin
						shift   <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						bit_cnt <= 4'h0;
						unique case (role)
							SEP_RL_SLAVE: begin
								// Busy: releasing leaves the ack high for polling
								if (!addr_match || busy) begin
									state <= SEP_DS_IDLE;
								end else begin
									rw        <= shift[0];
									state     <= SEP_DS_ACK;
									sda_drive <= 1'b1;
									role      <= SEP_RL_ADDR_HI;
								end
							end
							SEP_RL_ADDR_HI: begin
								addr_hi   <= shift;
								state     <= SEP_DS_ACK;
								sda_drive <= 1'b1;
								role      <= SEP_RL_ADDR_LO;
							end
							SEP_RL_ADDR_LO: begin
								counter    <= {addr_hi[0], shift};
								sel_hit    <= {addr_hi, shift} == SEL_ADDR;
								page_valid <= 8'h00;
								page_count <= 4'h0;
								state      <= SEP_DS_ACK;
								sda_drive  <= 1'b1;
								role       <= SEP_RL_DATA;
							end
							SEP_RL_DATA: begin
								page_valid[counter[2:0]] <= 1'b1;
								if (page_count != 4'h8) begin
									page_count <= page_count + 4'h1;
								end
								counter   <= next_page;
								state     <= SEP_DS_ACK;
								sda_drive <= 1'b1;
							end
						endcase
					end
				end
				SEP_DS_ACK: begin
					if (scl_fall) begin
						if (rw) begin
							shift     <= read_byte;
							sda_drive <= ~read_byte[7];
							counter   <= next_read;
							bit_cnt   <= 4'h1;
							state     <= SEP_DS_TX;
						end else begin
							sda_drive <= 1'b0;
							state     <= SEP_DS_RX;
						end
					end
				end
				SEP_DS_TX: begin
					if (scl_fall) begin
						if (bit_cnt == 4'h8) begin
							sda_drive <= 1'b0;
							state     <= SEP_DS_MACK;
						end else begin
							sda_drive <= ~shift[6];
							shift     <= {shift[6:0], 1'b0};
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
				end
				SEP_DS_MACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							state <= SEP_DS_IDLE;
						end else begin
							state <= SEP_DS_ACK;
						end
					end
				end
			endcase
		end
	end
endmodule // sep_device

// File: rtl/sep_host.sv
`timescale 1ns/1ps
`include "sep_defines.svh"
module sep_fifo #(
	parameter int WIDTH = `SEP_FIFO_WIDTH,
	parameter int DEPTH = `SEP_FIFO_DEPTH
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;

	// Depth must be a power of two for pointer wrap
	wire push = in_valid_i && in_ready_o;
	wire pull = count != '0 && (!out_valid_o || out_ready_i);

	assign in_ready_o = count < (AW + 1)'(DEPTH);

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wptr        <= '0;
			rptr        <= '0;
			count       <= '0;
			out_valid_o <= 1'b0;
			out_data_o  <= '0;
		end else begin
			if (push) begin
				wptr <= wptr + AW'(1);
			end
			if (pull) begin
				rptr       <= rptr + AW'(1);
				out_data_o <= mem[rptr];
			end
			if (pull) begin
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			count <= count + (AW + 1)'(push) - (AW + 1)'(pull);
		end
	end
endmodule // sep_fifo

module sep_host
	import sep_pkg::*;
#(
	parameter int LOAD_CYCLES = `SEP_LOAD_CYCLES
) (
	sep_if.host                                bus,
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          cmd_valid_i,
	input  wire sep_cmd_type                   cmd_i,
	output logic                               cmd_ready_o,
	output logic                               rsp_valid_o,
	input  wire logic                          rsp_ready_i,
	output logic [`SEP_FIFO_WIDTH-1:0]         rsp_data_o
);
	localparam logic [7:0] QUARTER = 8'(`SEP_QUARTER_CYC);

	sep_host_state_type state;
	logic [1:0]         sda_sync;
	logic [1:0]         step;
	logic [7:0]         tick;
	logic [3:0]         bit_idx;
	logic [7:0]         tx;
	logic [7:0]         rx;
	logic               read_op;
	logic               nack;
	logic               ack_bit;
	logic               loaded;
	logic [19:0]        load_cnt;
	logic               push;
	logic               scl;
	logic               sda_oe;
	logic               sda_out;
	logic               fifo_ready;

	wire sda_s     = sda_sync[1];
	wire take      = cmd_valid_i && cmd_ready_o;
	wire tick_hit  = tick == QUARTER - 8'h01;
	wire bit_drive = bit_idx == 4'h8 ? (read_op & ~nack) : (~read_op & ~tx[7]);

	assign bus.host_scl_o  = scl;
	assign bus.host_sda_o  = sda_out;
	assign bus.host_sda_oe = sda_oe;

	// Results stall new commands when the FIFO is full
	sep_fifo #(
		.WIDTH (`SEP_FIFO_WIDTH),
		.DEPTH (`SEP_FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push),
		.in_ready_o  (fifo_ready),
		.in_data_i   ({ack_bit, rx}),
		.out_valid_o (rsp_valid_o),
		.out_ready_i (rsp_ready_i),
		.out_data_o  (rsp_data_o)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sda_sync <= 2'h3;
			loaded   <= 1'b0;
			load_cnt <= 20'h00000;
		end else begin
			sda_sync <= {sda_sync[0], bus.sda};
			if (!loaded) begin
				loaded   <= load_cnt == 20'(LOAD_CYCLES - 1);
				load_cnt <= load_cnt + 20'h00001;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state       <= SEP_HS_IDLE;
			step        <= 2'h0;
			tick        <= 8'h00;
			bit_idx     <= 4'h0;
			tx          <= 8'h00;
			rx          <= 8'h00;
			read_op     <= 1'b0;
			nack        <= 1'b0;
			ack_bit     <= 1'b1;
			push        <= 1'b0;
			scl         <= 1'b1;
			sda_oe      <= 1'b0;
			sda_out     <= 1'b0;
			cmd_ready_o <= 1'b0;
		end else begin
			push        <= 1'b0;
			cmd_ready_o <= loaded && state == SEP_HS_IDLE && !take && !push && fifo_ready;
			if (take) begin
				tick    <= 8'h00;
				step    <= 2'h0;
				bit_idx <= 4'h0;
				tx      <= cmd_i.data;
				read_op <= cmd_i.op == SEP_OP_READ_ACK || cmd_i.op == SEP_OP_READ_NACK;
				nack    <= cmd_i.op == SEP_OP_READ_NACK;
				unique case (cmd_i.op)
					SEP_OP_START: state <= SEP_HS_START;
					SEP_OP_STOP:  state <= SEP_HS_STOP;
					SEP_OP_WRITE, SEP_OP_READ_ACK, SEP_OP_READ_NACK: state <= SEP_HS_BIT;
					default:      state <= SEP_HS_IDLE;
				endcase
			end else if (state != SEP_HS_IDLE) begin
				if (!tick_hit) begin
					tick <= tick + 8'h01;
				end else begin
					tick <= 8'h00;
					step <= step + 2'h1;
					unique case (step)
						2'h0: begin
							scl <= 1'b0;
							if (state == SEP_HS_BIT) begin
								sda_oe <= bit_drive;
							end else begin
								sda_oe <= state == SEP_HS_STOP;
							end
						end
						2'h1: scl <= 1'b1;
						2'h2: begin
							if (state == SEP_HS_START) begin
								sda_oe <= 1'b1;
							end else if (state == SEP_HS_STOP) begin
								sda_oe <= 1'b0;
							end else if (bit_idx == 4'h8) begin
								ack_bit <= sda_s;
							end else begin
								rx <= {rx[6:0], sda_s};
							end
						end
						2'h3: begin
							if (state == SEP_HS_STOP) begin
								state <= SEP_HS_IDLE;
							end else if (state == SEP_HS_START) begin
								scl   <= 1'b0;
								state <= SEP_HS_IDLE;
							end else begin
								scl <= 1'b0;
								tx  <= {tx[6:0], 1'b0};
								if (bit_idx == 4'h8) begin
									state <= SEP_HS_IDLE;
									push  <= 1'b1;
								end else begin
									bit_idx <= bit_idx + 4'h1;
								end
							end
						end
					endcase
				end
			end
		end
	end
endmodule // sep_host

// File: dv/sep_asserts.sv
`timescale 1ns/1ps
`include "sep_defines.svh"
module sep_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic ready_o,
	input wire logic busy_o
);
	logic       scl_q;
	logic       sda_q;
	logic [7:0] shreg;
	logic [3:0] bit_cnt;
	logic       past_first;
	logic       wr_on;
	logic       rd_on;
	logic       nacked;
	// Start and stop both restart the framing
	wire        cond_ev    = scl & scl_q & (sda ^ sda_q);
	wire        rise_ev    = scl & ~scl_q;
	wire        ack_ev     = rise_ev & (bit_cnt == 4'h8);
	wire        first_ack  = ack_ev & ~past_first;
	wire        hit        = (shreg[7:1] == {`SEP_DEV_TYPE, `SEP_SEL_RESET});
	wire [3:0]  next_bit   = ack_ev ? 4'h0 : bit_cnt + 4'h1;
	wire [7:0]  next_sh    = ack_ev ? shreg : {shreg[6:0], sda};
	wire        next_wr    = first_ack ? (hit & ~shreg[0] & ~sda) : wr_on;
	wire        next_rd    = first_ack ? (hit & shreg[0] & ~sda) : rd_on;
	wire        next_nak   = nacked | (ack_ev & past_first & rd_on & sda);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i | cond_ev) begin
			bit_cnt    <= 4'h0;
			past_first <= 1'b0;
			wr_on      <= 1'b0;
			rd_on      <= 1'b0;
			nacked     <= 1'b0;
		end else if (rise_ev) begin
			bit_cnt    <= next_bit;
			past_first <= past_first | ack_ev;
			wr_on      <= next_wr;
			rd_on      <= next_rd;
			nacked     <= next_nak;
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			shreg <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			shreg <= rise_ev ? next_sh : shreg;
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Device decides about fifty cycles before the ack rise; busy must be gone by then
	property p_addr_ack;
		first_ack && hit && ready_o && !busy_o && !$past(busy_o, 60) |-> !sda;
	endproperty
	a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
	property p_busy_rel;
		first_ack && busy_o |-> sda;
	endproperty
	a_busy_rel: assert property (p_busy_rel) else $error("acknowledge while busy");
	property p_mismatch;
		first_ack && !hit |-> sda;
	endproperty
	a_mismatch: assert property (p_mismatch) else $error("foreign address acknowledged");
	property p_data_ack;
		ack_ev && wr_on |-> !sda;
	endproperty
	a_data_ack: assert property (p_data_ack) else $error("write byte not acknowledged");
	property p_nack_rel;
		nacked && rise_ev |-> !dev_sda_oe;
	endproperty
	a_nack_rel: assert property (p_nack_rel) else $error("data after master nack");
	property p_dev_edge;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_dev_edge: assert property (p_dev_edge) else $error("device changed data with clock high");
	property p_hold_high;
		$rose(scl) |-> $stable(sda) [*8];
	endproperty
	a_hold_high: assert property (p_hold_high) else $error("data moved after clock rise");
	// Slack covers the device input synchronisers
	property p_ack_time;
		$fell(scl) && bit_cnt == 4'h8 && !past_first && hit && ready_o && !busy_o |-> ##[1:8] dev_sda_oe;
	endproperty
	a_ack_time: assert property (p_ack_time) else $error("acknowledge late");
endmodule // sep_asserts

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "sep_defines.svh"
module testbench
	import sep_pkg::*;
;
	localparam logic [7:0] ADW = {`SEP_DEV_TYPE, `SEP_SEL_RESET, 1'b0};
	localparam logic [7:0] ADR = ADW | 8'h01;
	logic        clk_i;
	logic        rst_i;
	logic        cmd_valid_i;
	sep_cmd_type cmd_i;
	logic        cmd_ready_o;
	logic        rsp_valid_o;
	logic        rsp_ready_i;
	logic [8:0]  rsp_data_o;
	logic        ready_o;
	logic        busy_o;
	logic [7:0]  mem [512];
	logic [7:0]  bad [3] = '{8'h30, 8'h52, 8'h5f};
	logic [8:0]  ctr;
	logic [8:0]  rq [$];
	logic [8:0]  r;
	int          num_errors;
	int          samples_checked;
	int          seed;
	int          n;
	sep_if i_sep_if ();
	sep_device #(.LOAD_CYCLES(50), .WRITE_CYCLES(3000)) i_sep_device (.bus(i_sep_if), .clk_i(clk_i),
		.rst_i(rst_i), .ready_o(ready_o), .busy_o(busy_o));
	sep_host #(.LOAD_CYCLES(60)) i_sep_host (.bus(i_sep_if), .clk_i(clk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
		.rsp_ready_i(rsp_ready_i), .rsp_data_o(rsp_data_o));
	sep_asserts i_sep_asserts (.clk_i(clk_i), .rst_i(rst_i), .scl(i_sep_if.scl), .sda(i_sep_if.sda),
		.dev_sda_oe(i_sep_if.dev_sda_oe), .ready_o(ready_o), .busy_o(busy_o));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1)
			rq.push_back(rsp_data_o);
	end
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input string w, input logic [8:0] e, input logic [8:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	// Bounded wait on ready; the take edge must pass before the next look
	task automatic send(input sep_op_type op, input logic [7:0] d);
		int t;
		for (t = 0; t < 5000 && cmd_ready_o !== 1'b1; t++)
			@(posedge clk_i);
		if (cmd_ready_o !== 1'b1) begin
			num_errors++;
			$display("wrong value cmd_ready_o expected 1 seen %b", cmd_ready_o);
		end
		cmd_valid_i <= 1'b1;
		cmd_i       <= '{op: op, data: d};
		@(posedge clk_i);
		cmd_valid_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic get_rsp(output logic [8:0] g);
		int t;
		for (t = 0; t < 3000 && rq.size() == 0; t++)
			@(posedge clk_i);
		g = (rq.size() > 0) ? rq.pop_front() : 'x;
	endtask
	task automatic xfer(input string w, input sep_op_type op, input logic [7:0] d, input logic [8:0] e);
		send(op, d);
		get_rsp(r);
		check(w, e, r);
	endtask
	task automatic wr(input logic [15:0] a, input int cnt);
		logic [7:0] d;
		send(SEP_OP_START, 8'h00);
		xfer("slave_wr", SEP_OP_WRITE, ADW, {1'b0, ADW});
		xfer("addr_hi", SEP_OP_WRITE, a[15:8], {1'b0, a[15:8]});
		xfer("addr_lo", SEP_OP_WRITE, a[7:0], {1'b0, a[7:0]});
		for (int i = 0; i < cnt; i++) begin
			d = 8'($random(seed));
			xfer("wr_data", SEP_OP_WRITE, d, {1'b0, d});
			mem[{a[8:3], 3'(a[2:0] + i)}] = d;
		end
		ctr = {a[8:3], 3'(a[2:0] + cnt)};
	endtask
	task automatic commit();
		send(SEP_OP_STOP, 8'h00);
		for (int p = 0; p < 8; p++) begin
			send(SEP_OP_START, 8'h00);
			send(SEP_OP_WRITE, ADW);
			get_rsp(r);
			send(SEP_OP_STOP, 8'h00);
			if (p == 0) begin
				check("poll_busy", {1'b1, ADW}, r);
				check("busy_flag", 9'h001, {8'h00, busy_o});
			end
			if (r === {1'b0, ADW})
				break;
		end
		check("poll_done", {1'b0, ADW}, r);
		check("busy_idle", 9'h000, {8'h00, busy_o});
	endtask
	task automatic rd(input int cnt);
		logic last;
		send(SEP_OP_START, 8'h00);
		xfer("slave_rd", SEP_OP_WRITE, ADR, {1'b0, ADR});
		for (int i = 0; i < cnt; i++) begin
			last = (i == cnt - 1);
			xfer("rd_data", last ? SEP_OP_READ_NACK : SEP_OP_READ_ACK, 8'h00, {last, mem[ctr]});
			ctr = ctr + 9'h001;
		end
	endtask
	initial begin
		seed            = 32'h0b6f;
		num_errors      = 0;
		samples_checked = 0;
		ctr             = 9'h000;
		rst_i           = 1'b1;
		cmd_valid_i     = 1'b0;
		cmd_i           = '0;
		rsp_ready_i     = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check("load_idle", 9'h003, {6'h00, ready_o, i_sep_if.scl, i_sep_if.sda});
		repeat (50) @(posedge clk_i);
		check("loaded", 9'h001, {8'h00, ready_o});
		wr(16'h01f8, 8);
		commit();
		wr(16'h0000, 8);
		commit();
		wr(16'h55fe, 0);
		rd(4);
		send(SEP_OP_STOP, 8'h00);
		// Ends on the page's last slot, so the counter folds back to the page start
		wr(16'h000c, 12);
		commit();
		rd(3);
		xfer("released", SEP_OP_READ_NACK, 8'h00, 9'h1ff);
		send(SEP_OP_STOP, 8'h00);
		foreach (bad[i]) begin
			send(SEP_OP_START, 8'h00);
			xfer("mismatch", SEP_OP_WRITE, bad[i], {1'b1, bad[i]});
			send(SEP_OP_STOP, 8'h00);
		end
		// Consumer stalls while the reads pile up in the buffer
		wr(16'h01f8, 0);
		rsp_ready_i <= 1'b0;
		send(SEP_OP_START, 8'h00);
		send(SEP_OP_WRITE, ADR);
		for (n = 1; n < 20; n++) begin
			repeat (2000) begin
				if (cmd_ready_o !== 1'b1)
					@(posedge clk_i);
			end
			if (cmd_ready_o !== 1'b1)
				break;
			send(SEP_OP_READ_ACK, 8'h00);
		end
		// Output register holds one word beyond the array
		check("fifo_words", 9'(`SEP_FIFO_DEPTH + 1), 9'(n));
		rsp_ready_i <= 1'b1;
		get_rsp(r);
		check("fifo_slave", {1'b0, ADR}, r);
		repeat (n - 1) begin
			get_rsp(r);
			check("fifo_data", {1'b0, mem[ctr]}, r);
			ctr = ctr + 9'h001;
		end
		xfer("fifo_last", SEP_OP_READ_NACK, 8'h00, {1'b1, mem[ctr]});
		send(SEP_OP_STOP, 8'h00);
		end_sim();
	end
	// Tests need about 80000 cycles
	initial begin
		repeat (95000) @(posedge clk_i);
		num_errors++;
		end_sim();
	end
endmodule // testbench
